/* File: rtl/git_defs.svh */
`ifndef GIT_DEFS_SVH
`define GIT_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define GIT_CTRL_OFS    12'h000
`define GIT_CNT_LO_OFS  12'h004
`define GIT_CNT_HI_OFS  12'h008
`define GIT_PER_LO_OFS  12'h00c
`define GIT_PER_HI_OFS  12'h010
`define GIT_STAT_OFS    12'h014
`define GIT_MASK_OFS    12'h018

// ****************************************
// Control field positions
// ****************************************
`define GIT_ON_BIT      15
`define GIT_GATE_BIT    7
`define GIT_PS_LSB      4
`define GIT_PAIR_BIT    3
`define GIT_SYNC_BIT    2
`define GIT_CS_BIT      1

// ****************************************
// Status bits
// ****************************************
`define GIT_EV_LO_BIT   0
`define GIT_EV_HI_BIT   1

// ****************************************
// Reset values and timing
// ****************************************
`define GIT_CTRL_RST    16'h0000
`define GIT_PER_RST     16'hffff
`define GIT_FLAG_DLY    2

`endif

/* File: rtl/git_pkg.sv */
package git_pkg;
  typedef enum logic [1:0] {GIT_IDLE, GIT_ARM, GIT_RUN} git_state_t;
  typedef logic [1:0] git_resp_t;
endpackage

/* File: rtl/git_timer.sv */
`timescale 1ns/10ps
`include "git_defs.svh"

// Behaviour
// - Gate rising edge starts accumulation; count advances only while gate high.
// - Control bit 7 enables gating, using bus clock when bit 1 is zero.
// - Clock select one disables gated accumulation entirely.
// - Gate synchronised internally; external sync bit ignored in gated mode.
// - Prescale 1:1 increments every bus clock while gate high.
// - Prescale N increments once per N bus clocks.
// - Count equal to period wraps to zero next tick; keeps counting.
// - Period match never raises the event flag in gated mode.
// - Gate fall stops counting, flag set four bus clocks after the synchronised fall.
// - Count retained at gate fall; software clears it.
// - With prescale, counting starts two to three ticks after on bit.
// - Pairable variant alone offers 32-bit counter and compare.
// - In 32-bit mode the event lands on the upper pair flag.
// - Control bit 3 pairs the two timers into one 32-bit counter.
// - Flag raises interrupt only when its enable bit is set.
module git_timer
  import git_pkg::*;
#(
  parameter bit PAIRABLE = 1'b1
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic        timer_input_pin,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output git_pkg::git_resp_t s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output git_pkg::git_resp_t s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq
);
  import git_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] ctrl_reg;
  logic [31:0] cnt_reg;
  logic [31:0] per_reg;
  logic [1:0]  stat_reg;
  logic [1:0]  mask_reg;
  logic [7:0]  psc_reg;
  logic [1:0]  arm_reg;
  logic [1:0]  sync_reg;
  logic        gate_d_reg;
  logic [`GIT_FLAG_DLY:0] ev_pipe_reg;
  logic        ev_hi_reg;
  git_state_t  state_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        aw_have_reg;
  logic        w_have_reg;

  // ****************************************
  // Control decode
  // ****************************************
  wire       on_bit   = ctrl_reg[`GIT_ON_BIT];
  wire       gate_en  = ctrl_reg[`GIT_GATE_BIT] & ~ctrl_reg[`GIT_CS_BIT];
  wire       pair_on  = PAIRABLE & ctrl_reg[`GIT_PAIR_BIT];
  wire [2:0] ps_sel   = ctrl_reg[`GIT_PS_LSB +: 3];
  wire [7:0] ps_last  = 8'((9'h001 << ps_sel) - 9'h001);
  wire [7:0] ps_fix   = (ps_sel == 3'h7) ? 8'hff : ps_last;
  wire       gate_s   = sync_reg[1];
  wire       gate_rise = gate_s & ~gate_d_reg;
  wire       gate_fall = ~gate_s & gate_d_reg;
  wire       tick     = (psc_reg == ps_fix);
  wire [31:0] cnt_w   = pair_on ? cnt_reg : {16'h0000, cnt_reg[15:0]};
  wire [31:0] per_w   = pair_on ? per_reg : {16'h0000, per_reg[15:0]};
  wire        match   = (cnt_w == per_w);
  wire [31:0] cnt_inc = match ? 32'h0000_0000 : cnt_w + 32'h0000_0001;
  wire        counting = on_bit & gate_en & (state_reg == GIT_RUN) & gate_s;
  wire        arm_done = (ps_sel == 3'h0) | (arm_reg == 2'h2);

  // ****************************************
  // Bus decode
  // ****************************************
  wire        aw_take  = s_axi_awvalid & s_axi_awready;
  wire        w_take   = s_axi_wvalid & s_axi_wready;
  wire        wr_go    = aw_have_reg & w_have_reg & ~s_axi_bvalid;
  wire        rd_take  = s_axi_arvalid & s_axi_arready;
  wire [31:0] wmask    = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                          {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  wire [31:0] wbits    = wdata_reg & wmask;
  // Unstrobed bytes keep their old contents
  wire [15:0] ctrl_wv  = (ctrl_reg & ~wmask[15:0]) | wbits[15:0];
  wire [15:0] pelo_wv  = (per_reg[15:0] & ~wmask[15:0]) | wbits[15:0];
  wire [15:0] pehi_wv  = (per_reg[31:16] & ~wmask[15:0]) | wbits[15:0];
  wire [15:0] cnlo_wv  = (cnt_reg[15:0] & ~wmask[15:0]) | wbits[15:0];
  wire [15:0] cnhi_wv  = (cnt_reg[31:16] & ~wmask[15:0]) | wbits[15:0];
  wire [1:0]  mask_wv  = (mask_reg & ~wmask[1:0]) | wbits[1:0];
  wire        wr_ctrl  = wr_go & (awaddr_reg == `GIT_CTRL_OFS);
  wire        wr_cnlo  = wr_go & (awaddr_reg == `GIT_CNT_LO_OFS);
  wire        wr_cnhi  = wr_go & (awaddr_reg == `GIT_CNT_HI_OFS);
  wire        wr_pelo  = wr_go & (awaddr_reg == `GIT_PER_LO_OFS);
  wire        wr_pehi  = wr_go & (awaddr_reg == `GIT_PER_HI_OFS);
  wire        wr_stat  = wr_go & (awaddr_reg == `GIT_STAT_OFS);
  wire        wr_mask  = wr_go & (awaddr_reg == `GIT_MASK_OFS);
  wire        wr_hit   = wr_ctrl | wr_cnlo | wr_cnhi | wr_pelo | wr_pehi | wr_stat | wr_mask;
  wire [31:0] cnt_wv   = {wr_cnhi ? cnhi_wv : cnt_reg[31:16],
                          wr_cnlo ? cnlo_wv : cnt_reg[15:0]};
  wire        ev_lo    = ev_pipe_reg[`GIT_FLAG_DLY] & ~ev_hi_reg;
  wire        ev_hi    = ev_pipe_reg[`GIT_FLAG_DLY] & ev_hi_reg;
  wire [1:0]  ev_set   = {ev_hi, ev_lo};
  wire [1:0]  stat_clr = wr_stat ? wbits[1:0] : 2'h0;
  wire [1:0]  stat_next = (stat_reg & ~stat_clr) | ev_set;
  wire [31:0] rd_mux;
  wire        rd_hit;

  assign rd_hit = (s_axi_araddr == `GIT_CTRL_OFS) | (s_axi_araddr == `GIT_CNT_LO_OFS) |
                  (s_axi_araddr == `GIT_CNT_HI_OFS) | (s_axi_araddr == `GIT_PER_LO_OFS) |
                  (s_axi_araddr == `GIT_PER_HI_OFS) | (s_axi_araddr == `GIT_STAT_OFS) |
                  (s_axi_araddr == `GIT_MASK_OFS);
  assign rd_mux = (s_axi_araddr == `GIT_CTRL_OFS)   ? {16'h0000, ctrl_reg} :
                  (s_axi_araddr == `GIT_CNT_LO_OFS) ? {16'h0000, cnt_reg[15:0]} :
                  (s_axi_araddr == `GIT_CNT_HI_OFS) ? {16'h0000, cnt_reg[31:16]} :
                  (s_axi_araddr == `GIT_PER_LO_OFS) ? {16'h0000, per_reg[15:0]} :
                  (s_axi_araddr == `GIT_PER_HI_OFS) ? {16'h0000, per_reg[31:16]} :
                  (s_axi_araddr == `GIT_STAT_OFS)   ? {30'h0, stat_reg} :
                  (s_axi_araddr == `GIT_MASK_OFS)   ? {30'h0, mask_reg} : 32'h0000_0000;

  // ****************************************
  // Gate sync and sequencing
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_reg   <= 2'h0;
      gate_d_reg <= 1'b0;
    end else if (clk_en) begin
      sync_reg   <= {sync_reg[0], timer_input_pin};
      gate_d_reg <= sync_reg[1];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= GIT_IDLE;
      arm_reg   <= 2'h0;
    end else if (clk_en) begin
      case (state_reg)
        GIT_IDLE: begin
          arm_reg <= 2'h0;
          if (on_bit & gate_en) begin
            state_reg <= GIT_ARM;
          end
        end
        GIT_ARM: begin
          if (!on_bit || !gate_en) begin
            state_reg <= GIT_IDLE;
          end else if (arm_done) begin
            state_reg <= GIT_RUN;
          end else if (tick) begin
            arm_reg <= arm_reg + 2'h1;
          end
        end
        default: begin
          if (!on_bit || !gate_en) begin
            state_reg <= GIT_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Prescaler and counter
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      psc_reg <= 8'h00;
    end else if (clk_en) begin
      if (!on_bit || gate_rise) begin
        psc_reg <= 8'h00;
      end else if (state_reg == GIT_ARM || counting) begin
        psc_reg <= tick ? 8'h00 : psc_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      if (wr_cnlo || wr_cnhi) begin
        cnt_reg <= cnt_wv;
      end else if (counting && tick) begin
        cnt_reg <= pair_on ? cnt_inc : {cnt_reg[31:16], cnt_inc[15:0]};
      end
    end
  end

  // ****************************************
  // Event delay and flags
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_pipe_reg <= '0;
      ev_hi_reg   <= 1'b0;
    end else if (clk_en) begin
      ev_pipe_reg <= {ev_pipe_reg[`GIT_FLAG_DLY-1:0],
                      gate_fall & on_bit & gate_en & (state_reg == GIT_RUN)};
      if (gate_fall) begin
        ev_hi_reg <= pair_on;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_reg <= 2'h0;
      irq      <= 1'b0;
    end else if (clk_en) begin
      stat_reg <= stat_next;
      irq      <= |(stat_next & mask_reg);
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `GIT_CTRL_RST;
      per_reg  <= {`GIT_PER_RST, `GIT_PER_RST};
      mask_reg <= 2'h0;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        ctrl_reg <= ctrl_wv & 16'h80fe;
      end
      if (wr_pelo) begin
        per_reg[15:0] <= pelo_wv;
      end
      if (wr_pehi) begin
        per_reg[31:16] <= pehi_wv;
      end
      if (wr_mask) begin
        mask_reg <= mask_wv;
      end
    end
  end

  // ****************************************
  // AXI4-Lite handshakes
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_have_reg   <= 1'b0;
      w_have_reg    <= 1'b0;
      awaddr_reg    <= 12'h000;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else if (clk_en) begin
      s_axi_awready <= ~aw_have_reg & ~aw_take;
      s_axi_wready  <= ~w_have_reg & ~w_take;
      if (aw_take) begin
        aw_have_reg <= 1'b1;
        awaddr_reg  <= {s_axi_awaddr[11:2], 2'h0};
      end
      if (w_take) begin
        w_have_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else if (clk_en) begin
      s_axi_arready <= ~s_axi_rvalid & ~rd_take & ~s_axi_arready;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  flag_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en & gate_fall & on_bit & gate_en & (state_reg == GIT_RUN)) ##1 clk_en[*4]
    |-> (stat_reg != 2'h0))
    else $error("event flag not set after gate fall");
  no_match_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ev_set != 2'h0) |-> $past(ev_pipe_reg[`GIT_FLAG_DLY-1]))
    else $error("flag set without gate fall");
  gate_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en & ~gate_s & ~wr_cnlo & ~wr_cnhi) |=> $stable(cnt_reg))
    else $error("count moved with gate low");
  cs_override_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_reg[`GIT_CS_BIT] |-> ~counting)
    else $error("gated count with external clock select");
  wrap_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en & counting & tick & match & ~wr_ctrl & ~wr_cnlo & ~wr_cnhi)
    |=> (cnt_w == 32'h0000_0000))
    else $error("count did not wrap at period");
  irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    irq |-> ($past(stat_next) & $past(mask_reg)) != 2'h0)
    else $error("irq without enabled flag");
  upper_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en & ev_pipe_reg[`GIT_FLAG_DLY] & ev_hi_reg) |=> stat_reg[`GIT_EV_HI_BIT])
    else $error("paired event not on upper flag");
  keep_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (clk_en & gate_fall & ~wr_cnlo & ~wr_cnhi) |=> $stable(cnt_reg))
    else $error("count cleared at gate fall");
  sync_pass_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en |=> (sync_reg[1] == $past(sync_reg[0])))
    else $error("synchroniser stage skipped");
endmodule // git_timer

/* File: tb/git_gate_src.sv */
`timescale 1ns/10ps

// ****************************************
// Gate pulse source at the timer input pin
// ****************************************
module git_gate_src (
  input  wire logic aclk,
  output logic      timer_input_pin
);
  initial timer_input_pin = 1'b0;

  // Level changes only just after a rising edge
  task automatic drive(input logic v);
    @(posedge aclk);
    timer_input_pin <= v;
  endtask
endmodule // git_gate_src

/* File: tb/test_gated_interval_timer.sv */
`timescale 1ns/10ps
`include "git_defs.svh"

module test_gated_interval_timer;
  import git_pkg::*;
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic        pin;
  logic [11:0] awaddr  = 12'h000;
  logic [11:0] araddr  = 12'h000;
  logic [31:0] wdata   = 32'h0;
  logic        clk_en  = 1'b1;
  logic [3:0]  wstrb   = 4'hf;
  logic [31:0] rdata;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  git_resp_t   bresp, rresp, rs;
  int          n_fail = 0;
  int          samples_checked = 0;

  always #25 aclk = ~aclk;

  git_gate_src u_gate (.aclk(aclk), .timer_input_pin(pin));

  git_timer u_dut (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .timer_input_pin(pin),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq)
  );

  // ****************************************
  // Reporting
  // ****************************************
  task automatic finish_test();
    $display("counts: %0d mismatches in %0d checks", n_fail, samples_checked);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic tmo();
    n_fail++;
    $display("unexpected at %0t: bus wait ran out", $time);
    finish_test();
  endtask

  function automatic logic [31:0] exp_wrap(input int n, input int p);
    return n % (p + 1);
  endfunction

  function automatic int exp_div(input int ps);
    return (ps == 7) ? 256 : (1 << ps);
  endfunction

  // ****************************************
  // AXI4-Lite master
  // ****************************************
  task automatic wr(input logic [11:0] a, input logic [15:0] d, input git_resp_t er = 2'h0);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {16'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int i = 0; i < 64; i++) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        chk(rs, er, "bresp");
        return;
      end
    end
    tmo();
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output git_resp_t r);
    logic ta, tr;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int i = 0; i < 64; i++) begin
      @(negedge aclk);
      ta = arvalid & arready;
      tr = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        return;
      end
    end
    tmo();
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string m);
    logic [31:0] d;
    git_resp_t   r;
    rd(a, d, r);
    chk(d, exp, m);
  endtask

  task automatic irqchk(input logic exp);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk(irq, exp, "irq");
  endtask

  // ****************************************
  // Setup and gate pulses
  // ****************************************
  task automatic cfg(input logic [15:0] c, input logic [15:0] clo, input logic [15:0] phi_lo);
    wr(`GIT_CTRL_OFS, 16'h0000);
    wr(`GIT_CNT_LO_OFS, clo);
    wr(`GIT_CNT_HI_OFS, 16'h0000);
    wr(`GIT_PER_LO_OFS, phi_lo);
    wr(`GIT_PER_HI_OFS, (c[`GIT_PAIR_BIT]) ? 16'hffff : 16'h0000);
    wr(`GIT_STAT_OFS, 16'h0003);
    wr(`GIT_MASK_OFS, 16'h0000);
    wr(`GIT_CTRL_OFS, c);
    repeat (40) @(posedge aclk);
  endtask

  task automatic gate(input int n);
    u_gate.drive(1'b1);
    repeat (n - 1) @(posedge aclk);
    u_gate.drive(1'b0);
    repeat (12) @(posedge aclk);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int          p, n, k, ps, nd;
    logic [31:0] c, d;
    p = $urandom(32'hab52);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rchk(`GIT_CTRL_OFS, {16'h0, `GIT_CTRL_RST}, "ctrl reset");
    rchk(`GIT_PER_LO_OFS, {16'h0, `GIT_PER_RST}, "period lo reset");
    rchk(`GIT_PER_HI_OFS, {16'h0, `GIT_PER_RST}, "period hi reset");
    rchk(`GIT_STAT_OFS, 32'h0, "status reset");
    rchk(`GIT_MASK_OFS, 32'h0, "mask reset");
    rd(12'h020, d, rs);
    chk(rs, 32'h2, "unmapped read resp");
    chk(d, 32'h0, "unmapped read data");
    wr(12'h020, 16'h1234, 2'h2);
    wstrb <= 4'h1;
    wr(`GIT_PER_LO_OFS, 16'h1234);
    wstrb <= 4'hf;
    rchk(`GIT_PER_LO_OFS, 32'h0000_ff34, "byte strobe");
    for (int it = 0; it < 4; it++) begin
      p = (it == 0) ? 32'hffff : 2 + $urandom % 30;
      n = 5 + $urandom % 60;
      cfg(16'h8080 | 16'(($urandom % 2) << `GIT_SYNC_BIT), 16'h0, p[15:0]);
      gate(n);
      rchk(`GIT_CNT_LO_OFS, exp_wrap(n, p), "count");
      rchk(`GIT_CNT_LO_OFS, exp_wrap(n, p), "count held");
      rchk(`GIT_STAT_OFS, 32'h1, "event flag");
      irqchk(1'b0);
      wr(`GIT_MASK_OFS, 16'h0001);
      irqchk(1'b1);
      wr(`GIT_STAT_OFS, 16'h0001);
      irqchk(1'b0);
      rchk(`GIT_STAT_OFS, 32'h0, "flag cleared");
    end
    cfg(16'h8080, 16'h0, 16'hffff);
    u_gate.drive(1'b1);
    repeat (9) @(posedge aclk);
    clk_en <= 1'b0;
    repeat (3 + $urandom % 8) @(posedge aclk);
    clk_en <= 1'b1;
    repeat (10) @(posedge aclk);
    u_gate.drive(1'b0);
    repeat (12) @(posedge aclk);
    rchk(`GIT_CNT_LO_OFS, 32'h14, "count across freeze");
    cfg(16'h8080, 16'h0, 16'h0003);
    u_gate.drive(1'b1);
    repeat (40) @(posedge aclk);
    rchk(`GIT_STAT_OFS, 32'h0, "no flag on wrap");
    u_gate.drive(1'b0);
    repeat (12) @(posedge aclk);
    rchk(`GIT_STAT_OFS, 32'h1, "flag on fall");
    for (int j = 0; j < 2; j++) begin
      ps = (j == 0) ? 7 : 1 + $urandom % 7;
      nd = exp_div(ps);
      cfg(16'h8080 | 16'(ps << `GIT_PS_LSB), 16'h0, 16'hffff);
      repeat (3 * nd) @(posedge aclk);
      k = 3 + $urandom % 8;
      gate(nd * k);
      rd(`GIT_CNT_LO_OFS, d, rs);
      chk(d >= k - 1 && d <= k, 1'b1, "prescaled count");
    end
    cfg(16'h8082, 16'h0, 16'hffff);
    gate(20);
    rchk(`GIT_CNT_LO_OFS, 32'h0, "no count on clock select");
    rchk(`GIT_STAT_OFS, 32'h0, "no flag on clock select");
    cfg(16'h8088, 16'hfff0, 16'hffff);
    n = 20 + $urandom % 40;
    gate(n);
    c = 32'hfff0 + n;
    rchk(`GIT_CNT_LO_OFS, {16'h0, c[15:0]}, "paired lo");
    rchk(`GIT_CNT_HI_OFS, {16'h0, c[31:16]}, "paired hi");
    rchk(`GIT_STAT_OFS, 32'h2, "upper flag");
    wr(`GIT_MASK_OFS, 16'h0002);
    irqchk(1'b1);
    finish_test();
  end
endmodule // test_gated_interval_timer
